// ---- pac_codec.sv ----
// codec model: bit clock, frame sync and data while the port is slave
// assumes the port samples these pins with its own clock
`timescale 1ns/1ns
module pac_codec #(
  parameter int HALF = 200,
  parameter logic [15:0] WORD = 16'hc35a
) (
  // control
  input wire logic i_en,
  // codec pins
  output logic o_bclk,
  output logic o_fs,
  output logic o_dat
);
  // whole 32-bit frames; the clock stands still between them when idle
  initial
  begin
    o_bclk = 1'b0;
    o_fs = 1'b0;
    o_dat = 1'b0;
    forever
    begin
      if (i_en !== 1'b1)
      begin
        o_dat = ~o_dat; // released line must not show a stale bit
        #HALF;
      end
      else
      begin
        for (int b = 0; b < 32; b++)
        begin
          o_bclk = 1'b1;
          o_fs = (b < 8);
          o_dat = (b < 16) ? WORD[15 - b] : ~o_dat;
          #HALF;
          o_bclk = 1'b0;
          #HALF;
        end
      end
    end
  end
endmodule // pac_codec

// ---- pac_core.sv ----
// voice port master clock/sync synthesis, slot serialiser and config words
// assumes codec pins arrive asynchronously; one 20 MHz clock, async reset
`timescale 1ns/1ns

// transmit sample buffer with valid/ready on both sides
module pac_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  generate
    if (D < 2 || W < 1)
    begin : g_bad
      $error("pac_fifo needs D >= 2 and W >= 1");
    end
  endgenerate
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [CW-1:0] cnt_q, cnt_d;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;
  wire [AW-1:0] wp_n = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
  wire [AW-1:0] rp_n = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
  assign cnt_d = cnt_q + CW'(push) - CW'(pop);
  assign o_data = mem_q[rp_q];
  // flags kept as flops so that full and empty are clean levels
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      o_ready <= 1'b1;
      o_valid <= 1'b0;
    end
    else
    begin
      if (push) wp_q <= wp_n;
      if (pop) rp_q <= rp_n;
      cnt_q <= cnt_d;
      o_ready <= cnt_d != CW'(D);
      o_valid <= cnt_d != '0;
    end
  end
  // storage has no reset; the flags guard it
  always_ff @(posedge i_clk)
  begin
    if (push) mem_q[wp_q] <= i_data;
  end
endmodule // pac_fifo

// Contract
// - master synthesises clock and sync from reference
// - low-rate source gives fixed rates, 8 kHz sync
// - high-rate source only when its enable set
// - high-rate long sync lasts 8 or 16 bits
// - high-rate clock equals step over limit scaled
// - high-rate sync divides clock by sync divider, or divider times 8
// - divider word holds limit, step, sync divider
// - port config resets to documented default word
// - bit 1 chooses master or slave clocking
// - bit 2 chooses long or short sync
// - bit 4 chooses low padding or sign fill
// - bit 5 chooses MSB or LSB first
// - bit 6 releases data pin after slot
// - bit 7 chooses falling or rising release edge
// - bits 22:21 pick 128, 256 or 512 kHz
// - bits 28:27 pick sample format and slot
module pac_core #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_tx_ready,
  // codec pins
  input wire logic i_pclk,
  output logic o_pclk,
  output logic o_pclk_oe,
  input wire logic i_psync,
  output logic o_psync,
  output logic o_psync_oe,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe
);
  logic [31:0] div_q, port_q;
  logic [15:0] rx_q, rsr_q, tsr_q;
  logic rx_new_q;
  logic [2:0] pre_q, s1_q, s2_q;
  logic pclk_prev_q, sync_prev_q;
  logic [12:0] acc_q;
  logic [10:0] bcnt_q;
  logic fifo_valid;
  logic [15:0] fifo_data;
  // register decode
  wire wr_div = i_wr && (i_addr == pac_pkg::OFF_DIV);
  wire wr_port = i_wr && (i_addr == pac_pkg::OFF_PORT);
  wire wr_tx = i_wr && (i_addr == pac_pkg::OFF_TX);
  wire rd_rx = i_rd && (i_addr == pac_pkg::OFF_RX);
  wire [31:0] stat_w = {29'h0, fifo_valid, o_tx_ready, rx_new_q};
  wire [31:0] rd_w = (i_addr == pac_pkg::OFF_DIV) ? div_q :
    (i_addr == pac_pkg::OFF_PORT) ? port_q :
    (i_addr == pac_pkg::OFF_RX) ? {16'h0, rx_q} :
    (i_addr == pac_pkg::OFF_STAT) ? stat_w : 32'h0;
  // config fields
  wire slave = port_q[pac_pkg::B_SLAVE];
  wire shrt = port_q[pac_pkg::B_SHORT];
  wire sgn = port_q[pac_pkg::B_SIGN];
  wire lsb = port_q[pac_pkg::B_LSB];
  wire rel = port_q[pac_pkg::B_REL];
  wire reledge = port_q[pac_pkg::B_RELEDGE];
  wire hr = port_q[pac_pkg::B_HR];
  wire lsync = port_q[pac_pkg::B_LSYNC];
  wire smult = port_q[pac_pkg::B_SMULT];
  wire [1:0] rate = port_q[pac_pkg::F_RATE +: 2];
  wire [1:0] fmt = port_q[pac_pkg::F_FMT +: 2];
  wire [2:0] gain = port_q[pac_pkg::F_GAIN +: 3];
  wire [12:0] dlim = div_q[pac_pkg::F_LIM +: 13];
  wire [7:0] dstep = div_q[pac_pkg::F_STEP +: 8];
  wire [7:0] sdiv = div_q[pac_pkg::F_SDIV +: 8];
  // rate selection: fixed table at low rate, divider word at high rate
  wire [7:0] step4 = (rate == pac_pkg::RATE128) ? pac_pkg::STEP128 :
    (rate == pac_pkg::RATE512) ? pac_pkg::STEP512 : pac_pkg::STEP256;
  wire [10:0] flen4 = (rate == pac_pkg::RATE128) ? pac_pkg::FLEN128 :
    (rate == pac_pkg::RATE512) ? pac_pkg::FLEN512 : pac_pkg::FLEN256;
  wire [12:0] lim = hr ? dlim : pac_pkg::DDS4_LIM;
  wire [7:0] step = hr ? dstep : step4;
  wire [10:0] flen = !hr ? flen4 :
    smult ? {3'h0, sdiv} : {sdiv, 3'h0};
  wire [10:0] flen_m1 = flen - 11'd1;
  wire [10:0] slen = (hr && lsync) ? pac_pkg::SYNC_LONG_LEN :
    pac_pkg::SYNC_SHORT_LEN;
  wire [10:0] slot = (fmt == pac_pkg::FMT8N) ? pac_pkg::SLOT_NARROW :
    pac_pkg::SLOT_WIDE;
  wire [10:0] slot_m1 = slot - 11'd1;
  // reference tick: every cycle stands in for the fast source
  wire tick = hr || (pre_q == pac_pkg::REF4_DIV - 3'd1);
  wire [13:0] sum = {1'b0, acc_q} + {6'h0, step};
  wire wrap = sum >= {1'b0, lim};
  wire [13:0] sum_w = wrap ? sum - {1'b0, lim} : sum;
  wire m_step = !slave && tick && wrap;
  // edges: own clock in master, synchronised pin in slave
  wire s_clk = s2_q[0];
  wire rise = slave ? (s_clk && !pclk_prev_q) : (m_step && !o_pclk);
  wire fall = slave ? (!s_clk && pclk_prev_q) : (m_step && o_pclk);
  wire sync_now = slave ? s2_q[1] : o_psync;
  wire fstart = fall && (shrt ? (sync_prev_q && !sync_now) :
    (!sync_prev_q && sync_now));
  wire [10:0] bcnt_n = (bcnt_q >= flen_m1) ? 11'd0 : bcnt_q + 11'd1;
  wire load = rise && (bcnt_n == 11'd0);
  // slot word build, sample taken at frame start
  wire [15:0] s = fifo_valid ? fifo_data : 16'h0;
  wire [15:0] w13 = sgn ? {{3{s[12]}}, s[12:0]} : {s[12:0], gain};
  wire [15:0] w8w = sgn ? {{8{s[7]}}, s[7:0]} : {s[7:0], 8'h00};
  wire [15:0] w8n = lsb ? {8'h00, s[7:0]} : {s[7:0], 8'h00};
  wire [15:0] slot_w = (fmt == pac_pkg::FMT13) ? w13 :
    (fmt == pac_pkg::FMT16) ? s :
    (fmt == pac_pkg::FMT8W) ? w8w : w8n;
  wire [15:0] rsr_n = lsb ? {s2_q[2], rsr_q[15:1]} :
    {rsr_q[14:0], s2_q[2]};
  wire rx_done = fall && (bcnt_q == slot_m1);

  pac_fifo #(
    .W(16),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(wr_tx),
    .o_ready(o_tx_ready),
    .i_data(i_wdata[15:0]),
    .o_valid(fifo_valid),
    .i_ready(load),
    .o_data(fifo_data)
  );

  // config words and read data
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_q <= pac_pkg::DIV_RST;
      port_q <= pac_pkg::PORT_RST;
      o_rdata <= 32'h0;
    end
    else
    begin
      if (wr_div) div_q <= i_wdata;
      if (wr_port) port_q <= i_wdata;
      o_rdata <= i_rd ? rd_w : 32'h0;
    end
  end
  // received word; a new capture beats the read that clears the flag
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_q <= 16'h0;
      rsr_q <= 16'h0;
      rx_new_q <= 1'b0;
    end
    else
    begin
      if (fall && bcnt_q < slot) rsr_q <= rsr_n;
      if (rx_done) rx_q <= rsr_n;
      if (rx_done) rx_new_q <= 1'b1;
      else if (rd_rx) rx_new_q <= 1'b0;
    end
  end
  // pin synchronisers: only the second stage is read by logic
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      pclk_prev_q <= 1'b0;
    end
    else
    begin
      s1_q <= {i_din, i_psync, i_pclk};
      s2_q <= s1_q;
      pclk_prev_q <= s_clk;
    end
  end
  // reference prescaler and phase accumulator
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pre_q <= 3'h0;
      acc_q <= 13'h0;
      o_pclk <= 1'b0;
    end
    else
    begin
      pre_q <= (tick || hr) ? 3'h0 : pre_q + 3'd1;
      if (!slave && tick) acc_q <= sum_w[12:0];
      if (m_step) o_pclk <= !o_pclk;
    end
  end
  // pin direction follows the clocking role
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pclk_oe <= 1'b0;
      o_psync_oe <= 1'b0;
    end
    else
    begin
      o_pclk_oe <= !slave;
      o_psync_oe <= !slave;
    end
  end
  // bit counter; slave realigns on the sync edge seen at a falling edge,
  // so the first slave frame may be misplaced
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bcnt_q <= 11'h0;
      sync_prev_q <= 1'b0;
      o_psync <= 1'b0;
    end
    else
    begin
      if (rise) bcnt_q <= bcnt_n;
      else if (fstart) bcnt_q <= 11'h0;
      if (fall) sync_prev_q <= sync_now;
      if (rise) o_psync <= shrt ? (bcnt_n == flen_m1) : (bcnt_n < slen);
    end
  end
  // serialiser: data changes on the rising clock edge
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tsr_q <= 16'h0;
      o_dout <= 1'b0;
    end
    else if (load)
    begin
      tsr_q <= lsb ? slot_w >> 1 : slot_w << 1;
      o_dout <= lsb ? slot_w[0] : slot_w[15];
    end
    else if (rise)
    begin
      tsr_q <= lsb ? tsr_q >> 1 : tsr_q << 1;
      o_dout <= lsb ? tsr_q[0] : tsr_q[15];
    end
  end
  // only the first slot is active; after it the pin is released only when rel is set
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_dout_oe <= 1'b1;
    else if (!rel || load)
      o_dout_oe <= 1'b1;
    else if (!reledge && fall && bcnt_q == slot_m1)
      o_dout_oe <= 1'b0;
    else if (reledge && rise && bcnt_n == slot)
      o_dout_oe <= 1'b0;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  dds_toggle_a: assert property (m_step |=> o_pclk != $past(o_pclk))
    else $error("clock did not toggle on wrap");
  // a switch to the fast source may legally bring ticks inside the low-rate gap
  low_rate_tick_a: assert property (!hr && tick |=> (hr || !tick) [*4])
    else $error("low-rate tick spacing wrong");
  high_rate_tick_a: assert property (hr |-> tick)
    else $error("high-rate tick missing");
  low_rate_table_a: assert property (!hr |-> lim == 13'd125 && flen == 11'(step) * 11'd2)
    else $error("low-rate table mismatch");
  rate_sel_a: assert property (!hr && rate == 2'b10 |-> step == 8'd32)
    else $error("512 kHz step wrong");
  frame_wrap_a: assert property (rise && bcnt_q == flen_m1 |=> bcnt_q == 11'd0)
    else $error("frame length wrong");
  long_sync_a: assert property (!slave && !shrt && rise && bcnt_n < slen |=> o_psync)
    else $error("long sync too short");
  short_sync_a: assert property (!slave && shrt && load |=> $fell(o_psync))
    else $error("short sync not ending at frame start");
  role_pins_a: assert property (slave ##1 slave |=> !o_pclk_oe && !o_psync_oe)
    else $error("slave drives clock or sync");
  order_a: assert property (load |=> o_dout == (lsb ? $past(slot_w[0]) : $past(slot_w[15])))
    else $error("first bit order wrong");
  pad_gain_a: assert property (load && fmt == 2'b00 && !sgn && !lsb |=> tsr_q[3:1] == $past(gain))
    else $error("gain not in pad bits");
  release_a: assert property (rel && !reledge && fall && bcnt_q == slot_m1 |=> !o_dout_oe)
    else $error("data pin not released");
  rise_release_a: assert property (rel && reledge && rise && bcnt_n == slot |=> !o_dout_oe)
    else $error("data pin not released on rising edge");
  drive_a: assert property (!rel |=> o_dout_oe)
    else $error("data pin released while drive set");
  rx_cap_a: assert property (rx_done |=> rx_new_q && rx_q == $past(rsr_n))
    else $error("received word not captured");
  reset_cfg_a: assert property ($rose(i_rst_n) |-> port_q == 32'h0080_0000)
    else $error("port config reset value wrong");

  frame_c: cover property (load ##[1:300] rx_done);
  slave_c: cover property (slave && fstart);
  full_c: cover property (!o_tx_ready);
  release_c: cover property (rel && $fell(o_dout_oe));
  long_sync_c: cover property (hr && lsync && !shrt && $rose(o_psync));
endmodule // pac_core

// ---- pac_pkg.sv ----
// constants for the voice port clock/sync generator and its config words
// assumes a 20 MHz system clock; offsets are byte addresses on a plain port
package pac_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_DIV = 8'h00;
  localparam logic [7:0] OFF_PORT = 8'h04;
  localparam logic [7:0] OFF_TX = 8'h08;
  localparam logic [7:0] OFF_RX = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  // reset values
  localparam logic [31:0] PORT_RST = 32'h0080_0000;
  localparam logic [31:0] DIV_RST = 32'h0808_0177;
  // port config bit positions
  localparam int B_SLAVE = 1;
  localparam int B_SHORT = 2;
  localparam int B_SIGN = 4;
  localparam int B_LSB = 5;
  localparam int B_REL = 6;
  localparam int B_RELEDGE = 7;
  localparam int B_HR = 11;
  localparam int B_LSYNC = 12;
  localparam int B_SMULT = 13;
  localparam int F_RATE = 21;
  localparam int F_FMT = 27;
  localparam int F_GAIN = 29;
  // divider config field positions
  localparam int F_LIM = 0;
  localparam int F_STEP = 16;
  localparam int F_SDIV = 24;
  // field encodings
  localparam logic [1:0] RATE256 = 2'b00;
  localparam logic [1:0] RATE128 = 2'b01;
  localparam logic [1:0] RATE512 = 2'b10;
  localparam logic [1:0] FMT13 = 2'b00;
  localparam logic [1:0] FMT16 = 2'b01;
  localparam logic [1:0] FMT8W = 2'b10;
  localparam logic [1:0] FMT8N = 2'b11;
  // timing: low-rate reference derived from the system clock
  localparam int CLK_HZ = 20_000_000;
  localparam int REF4_HZ = 4_000_000;
  localparam logic [2:0] REF4_DIV = 3'(CLK_HZ / REF4_HZ);
  // low-rate synthesis: f = step / 125 * 2 MHz
  localparam logic [12:0] DDS4_LIM = 13'd125;
  localparam logic [7:0] STEP128 = 8'd8;
  localparam logic [7:0] STEP256 = 8'd16;
  localparam logic [7:0] STEP512 = 8'd32;
  // frame lengths in bits for an 8 kHz frame, then sync and slot lengths in bits
  localparam logic [10:0] FLEN128 = 11'd16;
  localparam logic [10:0] FLEN256 = 11'd32;
  localparam logic [10:0] FLEN512 = 11'd64;
  localparam logic [10:0] SYNC_SHORT_LEN = 11'd8;
  localparam logic [10:0] SYNC_LONG_LEN = 11'd16;
  localparam logic [10:0] SLOT_NARROW = 11'd8;
  localparam logic [10:0] SLOT_WIDE = 11'd16;
endpackage

// ---- tb.sv ----
// self-checking bench for the voice port core
// assumes a 20 MHz clock and the codec model on the pins
`timescale 1ns/1ns
module tb;
  localparam int LIMIT = 90000;
  typedef struct {
    logic [31:0] cfg;
    logic [31:0] div;
    logic [15:0] smp;
    logic [15:0] exp;
    int width;
    int bits;
    int slen;
    int cyc;
  } pac_row_t;
  logic i_clk, i_rst_n, i_wr, i_rd, o_tx_ready;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic o_pclk, o_pclk_oe, o_psync, o_psync_oe, o_dout, o_dout_oe;
  logic bclk, fs, dat, en;
  logic pp = 1'b0, sp = 1'b0, pr, pf, sr, sf;
  int mismatches = 0, comparisons = 0, cycles = 0;
  // format rows run at the fast source to keep the run short
  pac_row_t rows [15] = '{
    '{32'h00800000, 32'h08080177, 16'h1234, 16'h91a0, 16, 32, 8, 2500},
    '{32'h00a00000, 32'h08080177, 16'h1234, 16'h91a0, 16, 16, 8, 2500},
    '{32'h00c00020, 32'h08080177, 16'h1234, 16'h0589, 16, 64, 8, 2500},
    '{32'h00800004, 32'h08080177, 16'h1234, 16'h91a0, 16, 32, 1, 2500},
    '{32'ha0800800, 32'h04010004, 16'h1234, 16'h91a5, 16, 32, 8, 256},
    '{32'h00800810, 32'h04010004, 16'h1234, 16'hf234, 16, 32, 8, 256},
    '{32'h08800800, 32'h04010004, 16'ha5c3, 16'ha5c3, 16, 32, 8, 256},
    '{32'h08800820, 32'h04010004, 16'ha5c3, 16'hc3a5, 16, 32, 8, 256},
    '{32'h10800800, 32'h04010004, 16'h0081, 16'h8100, 16, 32, 8, 256},
    '{32'h10800810, 32'h04010004, 16'h0081, 16'hff81, 16, 32, 8, 256},
    '{32'h18800800, 32'h04010004, 16'h0081, 16'h0081, 8, 32, 8, 256},
    '{32'h08801800, 32'h04010004, 16'h5a5a, 16'h5a5a, 16, 32, 16, 256},
    '{32'h08802800, 32'h28010004, 16'h5a5a, 16'h5a5a, 16, 40, 8, 320},
    '{32'h08800840, 32'h04010004, 16'h5a5a, 16'h5a5a, 16, 32, 8, 256},
    '{32'h088008c0, 32'h04010004, 16'h5a5a, 16'h5a5a, 16, 32, 8, 256}};

  pac_core dut (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_tx_ready,
    .i_pclk(bclk), .o_pclk, .o_pclk_oe, .i_psync(fs), .o_psync, .o_psync_oe,
    .i_din(dat), .o_dout, .o_dout_oe);
  pac_codec codec (.i_en(en), .o_bclk(bclk), .o_fs(fs), .o_dat(dat));

  // edge flags of the master pins, taken mid-cycle where they are settled
  always @(negedge i_clk)
  begin
    pr <= o_pclk & ~pp;
    pf <= ~o_pclk & pp;
    sr <= o_psync & ~sp;
    sf <= ~o_psync & sp;
    pp <= o_pclk;
    sp <= o_psync;
  end

  // hang guard
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // one frame from start to next start: slot bits, bit count, sync width
  task automatic measure(input logic sm, input int w, output logic [15:0] cap,
    output int b, output int s, output int c, output logic [1:0] oi, output logic oe);
    int n;
    int g;
    cap = '0;
    n = 0;
    c = 0;
    g = 0;
    oi = 2'b00;
    oe = 1'b0;
    do
    begin
      @(negedge i_clk);
      #1 g++;
    end while (!(pr && (sm ? sf : sr)) && g < 6000);
    b = 1;
    s = o_psync;
    while (g < 12000)
    begin
      @(negedge i_clk);
      #1 g++;
      c++;
      if (pr && (sm ? sf : sr))
        break;
      if (pf)
      begin
        if (n < w)
          cap = {cap[14:0], o_dout};
        // drive early in the slot, and state just after the last slot bit falls
        if (n == 1)
          oi[1] = o_dout_oe;
        if (n == w - 1)
          oi[0] = o_dout_oe;
        n++;
      end
      if (pr)
      begin
        b++;
        s += o_psync;
        oe = o_dout_oe;
      end
    end
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  initial
  begin
    pac_row_t r;
    logic [15:0] cap;
    logic [31:0] d;
    logic [1:0] oi;
    logic oe;
    int b, s, c, t, g;
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    en = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // format, rate and sync rows
    foreach (rows[k])
    begin
      r = rows[k];
      t = r.cfg[11] ? 0 : 10;
      wr(pac_pkg::OFF_DIV, r.div);
      wr(pac_pkg::OFF_PORT, r.cfg);
      measure(r.cfg[2], r.width, cap, b, s, c, oi, oe);
      wr(pac_pkg::OFF_TX, {16'h0000, r.smp});
      measure(r.cfg[2], r.width, cap, b, s, c, oi, oe);
      chk(cap, r.exp);
      chk(b, r.bits);
      chk(s, r.slen);
      chk(c >= r.cyc - t && c <= r.cyc + t, 1);
      chk({oi, oe, o_pclk_oe}, {1'b1, ~(r.cfg[6] & ~r.cfg[7]), ~r.cfg[6], 1'b1});
    end
    // fill the buffer past full, then drain it frame by frame
    wr(pac_pkg::OFF_PORT, 32'h08800800);
    measure(1'b0, 16, cap, b, s, c, oi, oe);
    for (int i = 0; i < 17; i++)
      wr(pac_pkg::OFF_TX, 32'h0100 + 32'(i));
    chk(o_tx_ready, 1'b0);
    // each measure skips the frame after the previous one, so it sees every
    // second sample; once the buffer is empty the slot carries zero
    for (int i = 0; i < 17; i++)
    begin
      measure(1'b0, 16, cap, b, s, c, oi, oe);
      chk(cap, (i < 8) ? 16'h0100 + 16'(2 * i) : 16'h0000);
    end
    chk(o_tx_ready, 1'b1);
    // slave: codec supplies clock and sync
    wr(pac_pkg::OFF_PORT, 32'h08800002);
    en <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk({o_pclk_oe, o_psync_oe}, 2'b00);
    for (int k = 0; k < 3; k++)
    begin
      d = '0;
      g = 0;
      while (!d[0] && g < 400)
      begin
        rd(pac_pkg::OFF_STAT, d);
        g++;
      end
      rd(pac_pkg::OFF_RX, d);
    end
    chk(d[15:0], 16'hc35a);
    en <= 1'b0;
    // second reset in mid-run, then register defaults and an unmapped place
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(pac_pkg::OFF_DIV, d);
    chk(d, pac_pkg::DIV_RST);
    wr(8'h14, 32'hffffffff);
    rd(pac_pkg::OFF_PORT, d);
    chk(d, 32'h00800000);
    rd(8'h14, d);
    chk(d, 32'h00000000);
    chk({o_pclk_oe, o_psync_oe}, 2'b11);
    print_verdict();
  end
endmodule // tb
